// File: verilog/nia_pkg.sv
// ==========================================================
// constants shared by the acknowledge logic
package nia_pkg;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] STATUS_OFFSET = 8'h00;
    localparam logic [7:0] REQUEST_OFFSET = 8'h04;
    localparam logic [7:0] MASK_OFFSET = 8'h08;
    localparam logic [7:0] LEVEL_OFFSET = 8'h0C;
    localparam logic [7:0] SERVICE_OFFSET = 8'h10;

    // ==========================================================
    // status word fields and reset value
    localparam int STATUS_ACCEPT_BIT = 7;
    localparam int STATUS_LEVEL_BIT = 1;
    localparam logic [7:0] STATUS_RESET = 8'h02;

    // ==========================================================
    // service register fields
    localparam int SERVICE_DEPTH_LSB = 0;
    localparam int SERVICE_NMI_BIT = 8;
    localparam int SERVICE_NMI_PEND_BIT = 9;
    localparam int SERVICE_DEFER_BIT = 10;

    // ==========================================================
    // vectors
    localparam logic [15:0] TRAP_VECTOR = 16'h003E;
    localparam logic [15:0] NMI_VECTOR_DEFAULT = 16'h0002;
    localparam logic [15:0] MASK_VECTOR_BASE_DEFAULT = 16'h0004;

    // ==========================================================
    // ahb encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

    // ==========================================================
    // class of the instruction that just completed
    typedef enum logic [2:0] {
        NIA_OP_NORMAL = 3'h0,
        NIA_OP_DEFER = 3'h1,
        NIA_OP_ACCEPT_ON = 3'h3,
        NIA_OP_MASK_ALL = 3'h2,
        NIA_OP_TRAP = 3'h6,
        NIA_OP_TRAP_RETURN = 3'h7,
        NIA_OP_IRQ_RETURN = 3'h5
    } nia_op_t;

    // kind of acknowledge
    typedef enum logic [1:0] {
        NIA_ACK_MASKABLE = 2'h0,
        NIA_ACK_NMI = 2'h1,
        NIA_ACK_TRAP = 2'h3
    } nia_ack_t;

endpackage : nia_pkg

// File: verilog/nia_arb_if.sv
`timescale 1ns/1ps
// ==========================================================
// request arbitration carrier
interface nia_arb_if #(
    parameter int NUM_SOURCES = 24
);
    logic [NUM_SOURCES-1:0] eligible;
    logic [NUM_SOURCES-1:0] level;
    logic found;
    logic [$clog2(NUM_SOURCES)-1:0] index;
    logic win_level;

    modport core (output eligible, output level, input found, input index, input win_level);
    modport arb (input eligible, input level, output found, output index, output win_level);
endinterface : nia_arb_if

// File: verilog/nia_arbiter.sv
`timescale 1ns/1ps
// ==========================================================
// picks one eligible maskable source
module nia_arbiter #(
    parameter int NUM_SOURCES = 24
) (
    nia_arb_if.arb arb
);
    localparam int IW = $clog2(NUM_SOURCES);

    logic [NUM_SOURCES-1:0] high_vec;
    logic [NUM_SOURCES-1:0] low_vec;
    logic [NUM_SOURCES-1:0] pick_vec;
    logic [NUM_SOURCES-1:0] pick_onehot;
    logic [IW-1:0] enc [NUM_SOURCES+1];

    // ==========================================================
    // level first, fixed order (lowest index) only breaks ties
    assign high_vec = arb.eligible & ~arb.level;
    assign low_vec = arb.eligible & arb.level;
    assign pick_vec = (high_vec != '0) ? high_vec : low_vec;
    assign pick_onehot = pick_vec & (~pick_vec + 1'b1);

    assign enc[0] = '0;
    genvar i;
    generate
        for (i = 0; i < NUM_SOURCES; i++)
        begin : g_enc
            assign enc[i+1] = pick_onehot[i] ? IW'(i) : enc[i];
        end
    endgenerate

    assign arb.found = (pick_vec != '0);
    assign arb.index = enc[NUM_SOURCES];
    assign arb.win_level = (high_vec == '0);

endmodule : nia_arbiter

// File: verilog/nia_core.sv
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module nia_core #(
    parameter int NUM_SOURCES = 24,
    parameter int STACK_DEPTH = 8,
    parameter logic [15:0] NMI_VECTOR = nia_pkg::NMI_VECTOR_DEFAULT,
    parameter logic [15:0] MASK_VECTOR_BASE = nia_pkg::MASK_VECTOR_BASE_DEFAULT
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic instr_done,
    input wire logic [2:0] instr_op,
    input wire logic nmi_req,
    input wire logic [NUM_SOURCES-1:0] src_req_set,
    output logic ack_valid,
    output logic [1:0] ack_kind,
    output logic [$clog2(NUM_SOURCES)-1:0] ack_source,
    output logic [15:0] ack_vector,
    output logic [7:0] status_word
);
    localparam int IW = $clog2(NUM_SOURCES);
    localparam int SPW = $clog2(STACK_DEPTH + 1);

    // ==========================================================
    // bus slave state
    logic rd_pend_reg;
    logic wr_pend_reg;
    logic [7:0] addr_reg;
    logic hreadyout_reg;
    logic [31:0] hrdata_reg;
    logic addr_take;
    logic wr_status;
    logic wr_request;
    logic wr_mask;
    logic wr_level;
    logic [31:0] read_value;

    // ==========================================================
    // interrupt state
    logic accept_reg;
    logic service_level_reg;
    logic in_nmi_reg;
    logic nmi_pend_reg;
    logic sw_defer_reg;
    logic [NUM_SOURCES-1:0] request_reg;
    logic [NUM_SOURCES-1:0] request_next;
    logic [NUM_SOURCES-1:0] mask_reg;
    logic [NUM_SOURCES-1:0] level_reg;
    logic [SPW-1:0] sp_reg;
    logic [2:0] stack_mem [STACK_DEPTH];
    logic ack_valid_reg;
    logic [1:0] ack_kind_reg;
    logic [IW-1:0] ack_source_reg;
    logic [15:0] ack_vector_reg;

    // ==========================================================
    // decision terms
    nia_pkg::nia_op_t op;
    logic op_defers;
    logic may_ack;
    logic take_trap;
    logic take_nmi;
    logic take_mask;
    logic do_push;
    logic do_pop;
    logic flag_access;

    nia_arb_if #(.NUM_SOURCES(NUM_SOURCES)) arb_bus ();

    nia_arbiter #(.NUM_SOURCES(NUM_SOURCES)) u_arbiter (
        .arb(arb_bus)
    );

    assign op = nia_pkg::nia_op_t'(instr_op);
    assign arb_bus.eligible = request_reg & ~mask_reg;
    assign arb_bus.level = level_reg;

    // ==========================================================
    // acceptance at an instruction boundary
    always_comb
    begin
        op_defers = (op == nia_pkg::NIA_OP_DEFER) || (op == nia_pkg::NIA_OP_ACCEPT_ON) ||
                    (op == nia_pkg::NIA_OP_MASK_ALL) || (op == nia_pkg::NIA_OP_TRAP_RETURN) ||
                    (op == nia_pkg::NIA_OP_IRQ_RETURN);
        // the trap vectors itself, so nothing else shares its boundary
        may_ack = instr_done && !op_defers && !sw_defer_reg &&
                  (op != nia_pkg::NIA_OP_TRAP);
        take_trap = instr_done && (op == nia_pkg::NIA_OP_TRAP);
        take_nmi = may_ack && nmi_pend_reg && !in_nmi_reg;
        // service level 0 means a high level source is in service
        take_mask = may_ack && !take_nmi && accept_reg && service_level_reg &&
                    !in_nmi_reg && arb_bus.found;
        do_push = take_trap || take_nmi || take_mask;
        do_pop = instr_done && ((op == nia_pkg::NIA_OP_TRAP_RETURN) ||
                                (op == nia_pkg::NIA_OP_IRQ_RETURN));
    end

    // ==========================================================
    // bus slave: writes take no wait, reads one wait state
    assign addr_take = hsel && hready && (htrans == nia_pkg::HTRANS_NONSEQ);
    assign wr_status = wr_pend_reg && (addr_reg == nia_pkg::STATUS_OFFSET);
    assign wr_request = wr_pend_reg && (addr_reg == nia_pkg::REQUEST_OFFSET);
    assign wr_mask = wr_pend_reg && (addr_reg == nia_pkg::MASK_OFFSET);
    assign wr_level = wr_pend_reg && (addr_reg == nia_pkg::LEVEL_OFFSET);
    assign flag_access = addr_take && ((haddr[7:0] == nia_pkg::REQUEST_OFFSET) ||
                                       (haddr[7:0] == nia_pkg::MASK_OFFSET) ||
                                       (haddr[7:0] == nia_pkg::LEVEL_OFFSET) ||
                                       (haddr[7:0] == nia_pkg::STATUS_OFFSET));

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_pend_reg <= 1'b0;
            wr_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
            hreadyout_reg <= 1'b1;
        end
        else
        begin
            rd_pend_reg <= addr_take && !hwrite;
            wr_pend_reg <= addr_take && hwrite;
            if (addr_take)
            begin
                addr_reg <= haddr[7:0];
            end
            hreadyout_reg <= !(addr_take && !hwrite);
        end
    end

    always_comb
    begin
        read_value = 32'h0000_0000;
        unique case (addr_reg)
            nia_pkg::STATUS_OFFSET:
            begin
                read_value[nia_pkg::STATUS_ACCEPT_BIT] = accept_reg;
                read_value[nia_pkg::STATUS_LEVEL_BIT] = service_level_reg;
            end
            nia_pkg::REQUEST_OFFSET: read_value = 32'(request_reg);
            nia_pkg::MASK_OFFSET: read_value = 32'(mask_reg);
            nia_pkg::LEVEL_OFFSET: read_value = 32'(level_reg);
            nia_pkg::SERVICE_OFFSET:
            begin
                read_value[nia_pkg::SERVICE_DEPTH_LSB +: SPW] = sp_reg;
                read_value[nia_pkg::SERVICE_NMI_BIT] = in_nmi_reg;
                read_value[nia_pkg::SERVICE_NMI_PEND_BIT] = nmi_pend_reg;
                read_value[nia_pkg::SERVICE_DEFER_BIT] = sw_defer_reg;
            end
            default: read_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata_reg <= 32'h0000_0000;
        end
        else if (rd_pend_reg)
        begin
            hrdata_reg <= read_value;
        end
    end

    // ==========================================================
    // accesses to the status, request, mask and level registers hold off the next boundary
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sw_defer_reg <= 1'b0;
        end
        else if (flag_access)
        begin
            sw_defer_reg <= 1'b1;
        end
        else if (instr_done)
        begin
            sw_defer_reg <= 1'b0;
        end
    end

    // ==========================================================
    // request, mask and level flags; a hardware set beats any clear
    always_comb
    begin
        request_next = wr_request ? hwdata[NUM_SOURCES-1:0] : request_reg;
        if (take_mask)
        begin
            request_next[arb_bus.index] = 1'b0;
        end
        request_next = request_next | src_req_set;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            request_reg <= '0;
            mask_reg <= '1;
            level_reg <= '1;
        end
        else
        begin
            request_reg <= request_next;
            if (wr_mask)
            begin
                mask_reg <= hwdata[NUM_SOURCES-1:0];
            end
            if (wr_level)
            begin
                level_reg <= hwdata[NUM_SOURCES-1:0];
            end
        end
    end

    // only one nmi is held however many arrive while it waits
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            nmi_pend_reg <= 1'b0;
        end
        else if (nmi_req)
        begin
            nmi_pend_reg <= 1'b1;
        end
        else if (take_nmi)
        begin
            nmi_pend_reg <= 1'b0;
        end
    end

    // ==========================================================
    // saved status stack; a push past the top is dropped
    always_ff @(posedge hclk)
    begin
        if (do_push && (sp_reg < SPW'(STACK_DEPTH)))
        begin
            stack_mem[sp_reg[$clog2(STACK_DEPTH)-1:0]] <=
                {accept_reg, service_level_reg, in_nmi_reg};
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sp_reg <= '0;
        end
        else if (do_push && (sp_reg < SPW'(STACK_DEPTH)))
        begin
            sp_reg <= sp_reg + 1'b1;
        end
        else if (do_pop && (sp_reg != '0))
        begin
            sp_reg <= sp_reg - 1'b1;
        end
    end

    // ==========================================================
    // status word flags
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            accept_reg <= nia_pkg::STATUS_RESET[nia_pkg::STATUS_ACCEPT_BIT];
            service_level_reg <= nia_pkg::STATUS_RESET[nia_pkg::STATUS_LEVEL_BIT];
            in_nmi_reg <= 1'b0;
        end
        else if (take_trap)
        begin
            accept_reg <= 1'b0;
        end
        else if (take_nmi)
        begin
            accept_reg <= 1'b0;
            service_level_reg <= 1'b0;
            in_nmi_reg <= 1'b1;
        end
        else if (take_mask)
        begin
            accept_reg <= 1'b0;
            service_level_reg <= arb_bus.win_level;
        end
        else if (do_pop && (sp_reg != '0))
        begin
            {accept_reg, service_level_reg, in_nmi_reg} <=
                stack_mem[$clog2(STACK_DEPTH)'(sp_reg - 1'b1)];
        end
        else if (instr_done && (op == nia_pkg::NIA_OP_ACCEPT_ON))
        begin
            accept_reg <= 1'b1;
        end
        else if (instr_done && (op == nia_pkg::NIA_OP_MASK_ALL))
        begin
            accept_reg <= 1'b0;
        end
        else if (wr_status)
        begin
            accept_reg <= hwdata[nia_pkg::STATUS_ACCEPT_BIT];
            service_level_reg <= hwdata[nia_pkg::STATUS_LEVEL_BIT];
        end
    end

    // ==========================================================
    // acknowledge to the sequencer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ack_valid_reg <= 1'b0;
            ack_kind_reg <= nia_pkg::NIA_ACK_MASKABLE;
            ack_source_reg <= '0;
            ack_vector_reg <= 16'h0000;
        end
        else
        begin
            ack_valid_reg <= do_push;
            if (take_trap)
            begin
                ack_kind_reg <= nia_pkg::NIA_ACK_TRAP;
                ack_vector_reg <= nia_pkg::TRAP_VECTOR;
            end
            else if (take_nmi)
            begin
                ack_kind_reg <= nia_pkg::NIA_ACK_NMI;
                ack_vector_reg <= NMI_VECTOR;
            end
            else if (take_mask)
            begin
                ack_kind_reg <= nia_pkg::NIA_ACK_MASKABLE;
                ack_source_reg <= arb_bus.index;
                ack_vector_reg <= MASK_VECTOR_BASE + 16'({arb_bus.index, 1'b0});
            end
        end
    end

    assign hreadyout = hreadyout_reg;
    assign hresp = nia_pkg::HRESP_OKAY;
    assign hrdata = hrdata_reg;
    assign ack_valid = ack_valid_reg;
    assign ack_kind = ack_kind_reg;
    assign ack_source = ack_source_reg;
    assign ack_vector = ack_vector_reg;
    assign status_word = {accept_reg, 5'h00, service_level_reg, 1'b0};

endmodule : nia_core

// File: verification/nia_core_properties.sv
`timescale 1ns/1ps
// ==========================================================
// acknowledge checks on the top ports
module nia_core_properties #(
    parameter int NUM_SOURCES = 24,
    parameter logic [15:0] NMI_VECTOR = 16'h0002,
    parameter logic [15:0] MASK_VECTOR_BASE = 16'h0004
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic instr_done,
    input wire logic [2:0] instr_op,
    input wire logic ack_valid,
    input wire logic [1:0] ack_kind,
    input wire logic [$clog2(NUM_SOURCES)-1:0] ack_source,
    input wire logic [15:0] ack_vector,
    input wire logic [7:0] status_word
);
    default clocking chk_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    chk_trap_acks: assert property (
        instr_done && instr_op == 3'h6 |=> ack_valid && ack_kind == 2'h3 && ack_vector == 16'h003E)
        else $error("trap boundary not vectored");
    chk_ack_clears_accept: assert property (
        ack_valid |-> !status_word[7])
        else $error("accept flag still set after acknowledge");
    chk_defer_ops: assert property (
        instr_done && instr_op inside {3'h1, 3'h2, 3'h3, 3'h5, 3'h7} |=> !ack_valid)
        else $error("acknowledge after deferring instruction");
    chk_ack_at_boundary: assert property (
        ack_valid |-> $past(instr_done))
        else $error("acknowledge without instruction boundary");
    chk_nmi_vector: assert property (
        ack_valid && ack_kind == 2'h1 |-> ack_vector == NMI_VECTOR && !status_word[1])
        else $error("nmi acknowledge wrong vector or level");
    chk_mask_vector: assert property (
        ack_valid && ack_kind == 2'h0 |-> ack_vector == MASK_VECTOR_BASE + {ack_source, 1'b0})
        else $error("maskable vector does not match source");
    chk_accept_gates: assert property (
        instr_done && instr_op == 3'h0 && !status_word[7] |=> !(ack_valid && ack_kind == 2'h0))
        else $error("maskable taken with accept clear");
    chk_high_blocks: assert property (
        instr_done && instr_op == 3'h0 && !status_word[1] |=> !(ack_valid && ack_kind == 2'h0))
        else $error("maskable nested under high service");
endmodule : nia_core_properties

// File: verification/nia_cpu_model.sv
`timescale 1ns/1ps
// ==========================================================
// instruction sequencer and request sources
module nia_cpu_model #(
    parameter int NS = 24
) (
    input wire logic hclk,
    output logic instr_done,
    output logic [2:0] instr_op,
    output logic nmi_req,
    output logic [NS-1:0] src_req_set
);
    initial
    begin
        instr_done = 1'b0;
        instr_op = 3'h0;
        nmi_req = 1'b0;
        src_req_set = '0;
    end

    // the directed run leaves trap handlers only with trap_return_op
    task automatic run(input logic [2:0] op);
        @(posedge hclk);
        instr_done <= 1'b1;
        instr_op <= op;
        @(posedge hclk);
        instr_done <= 1'b0;
        // class lines are meaningless between boundaries, so do not hold them
        instr_op <= ~op;
    endtask : run

    task automatic raise(input logic n, input logic [NS-1:0] s);
        @(posedge hclk);
        nmi_req <= n;
        src_req_set <= s;
        @(posedge hclk);
        nmi_req <= 1'b0;
        src_req_set <= '0;
    endtask : raise
endmodule : nia_cpu_model

// File: verification/test_nested_interrupt_acknowledge.sv
`timescale 1ns/1ps
// ==========================================================
// self-checking bench with a reference model
module test_nested_interrupt_acknowledge;
    localparam int NS = 24;
    localparam logic [31:0] ALL = 32'h00FFFFFF;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, instr_done, nmi_req, ack_valid;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans, ack_kind;
    logic [2:0] hsize, instr_op;
    logic [NS-1:0] src_req_set;
    logic [$clog2(NS)-1:0] ack_source;
    logic [15:0] ack_vector;
    logic [7:0] status_word;
    int failures, total_checks, cycles, seed;
    bit acc, service_level_flag, innmi, npend, dfr;
    logic [31:0] req, msk, lvl;
    logic [2:0] stk[$];
    logic [7:0] rd_tbl[6] = '{8'h10, 8'h00, 8'h04, 8'h08, 8'h0C, 8'h20};
    int dir_tbl[15] = '{0, 3, 0, 8, 6, 0, 8, 0, 5, 0, 5, 7, 5, 0, 0};
    logic [2:0] op_tbl[8] = '{3'h0, 3'h0, 3'h6, 3'h1, 3'h2, 3'h3, 3'h5, 3'h7};

    nia_core #(.NUM_SOURCES(NS)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .instr_done(instr_done), .instr_op(instr_op), .nmi_req(nmi_req),
        .src_req_set(src_req_set), .ack_valid(ack_valid), .ack_kind(ack_kind),
        .ack_source(ack_source), .ack_vector(ack_vector), .status_word(status_word));
    nia_cpu_model #(.NS(NS)) u_cpu (.hclk(hclk), .instr_done(instr_done),
        .instr_op(instr_op), .nmi_req(nmi_req), .src_req_set(src_req_set));

    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // ==========================================================
    // reporting
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            summarize();
        end
    end

    // ==========================================================
    // bus master and reference model
    task automatic bus(input logic [7:0] a, input bit w, input logic [31:0] d);
        logic [31:0] e;
        e = (a == 8'h00) ? {24'h0, acc, 5'h0, service_level_flag, 1'b0} : (a == 8'h04) ? req :
            (a == 8'h08) ? msk : (a == 8'h0C) ? lvl : 32'h0;
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        check(32'(hresp), 32'(nia_pkg::HRESP_OKAY));
        if (!w)
            check(hrdata, e);
        if (w && a == 8'h00)
            {acc, service_level_flag} = {d[7], d[1]};
        if (w && a == 8'h04)
            req = d & ALL;
        if (w && a == 8'h08)
            msk = d & ALL;
        if (w && a == 8'h0C)
            lvl = d & ALL;
        // access to the status, request, mask or level register holds off the next boundary
        if (a <= 8'h0C)
            dfr = 1'b1;
    endtask : bus

    task automatic src(input logic n, input logic [NS-1:0] s);
        u_cpu.raise(n, s);
        req = req | 32'(s);
        if (n)
            npend = 1'b1;
    endtask : src

    task automatic push();
        // frames past the stack depth are lost, as in the core
        if (stk.size() < 8)
            stk.push_back({acc, service_level_flag, innmi});
    endtask : push

    task automatic step(input logic [2:0] op);
        int w;
        logic [31:0] el;
        logic [3:0] ek;
        logic [15:0] ev;
        w = 0;
        ek = 4'h0;
        ev = 16'h0;
        el = req & ~msk;
        u_cpu.run(op);
        if (op == 3'h6)
        begin
            push();
            acc = 1'b0;
            {ek, ev} = {4'hB, 16'h003E};
        end
        else if (dfr || op != 3'h0)
        begin
            if (op == 3'h3 || op == 3'h2)
                acc = (op == 3'h3);
            if ((op == 3'h5 || op == 3'h7) && stk.size() > 0)
                {acc, service_level_flag, innmi} = stk.pop_back();
        end
        else if (npend && !innmi)
        begin
            push();
            {acc, service_level_flag, innmi, npend} = 4'b0010;
            {ek, ev} = {4'h9, 16'h0002};
        end
        else if (acc && service_level_flag && !innmi && el != 32'h0)
        begin
            for (int i = NS - 1; i >= 0; i--)
                w = el[i] && lvl[i] ? i : w;
            for (int i = NS - 1; i >= 0; i--)
                w = el[i] && !lvl[i] ? i : w;
            push();
            {acc, service_level_flag} = {1'b0, lvl[w]};
            req[w] = 1'b0;
            {ek, ev} = {4'h8, 16'h0004 + 16'(2 * w)};
        end
        dfr = 1'b0;
        #1;
        check(32'(ack_valid), 32'(ek[3]));
        if (ek[3])
            check({ack_kind, ack_vector}, {ek[1:0], ev});
        if (ek == 4'h8)
            check(32'(ack_source), w);
        check(32'(status_word), {24'h0, acc, 5'h0, service_level_flag, 1'b0});
    endtask : step

    // ==========================================================
    // main sequence
    initial
    begin
        {failures, total_checks, cycles, seed} = {32'h0, 32'h0, 32'h0, 32'h0dfe};
        {hresetn, hsel, hwrite, haddr, htrans, hsize, hwdata} = {3'b0, 32'h0, 2'h0, 3'h2, 32'h0};
        {acc, service_level_flag, innmi, npend, dfr} = 5'b01000;
        {req, msk, lvl} = {32'h0, ALL, ALL};
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        bus(8'h20, 1'b1, 32'hFFFFFFFF);
        foreach (rd_tbl[i])
            bus(rd_tbl[i], 1'b0, 32'h0);
        step(3'h0);
        bus(8'h0C, 1'b1, 32'h00FFFFDF);
        step(3'h0);
        bus(8'h08, 1'b1, 32'h0);
        step(3'h0);
        bus(8'h00, 1'b1, 32'h82);
        step(3'h0);
        src(1'b0, 24'h000224);
        foreach (dir_tbl[i])
            if (dir_tbl[i] == 8)
                src(1'b1, '0);
            else
                step(3'(dir_tbl[i]));
        for (int k = 0; k < 300; k++)
        begin
            r = $random(seed);
            case (r[3:0])
                4'h0: bus(8'h00, 1'b1, r);
                4'h1: bus(8'h08, 1'b1, r >> 8);
                4'h2: bus(8'h0C, 1'b1, r);
                4'h3: bus(8'h04, 1'b1, r);
                4'h4: bus(8'h00, 1'b0, 32'h0);
                4'h5: src(r[4], r[NS+7:8]);
                default: step(op_tbl[r[6:4]]);
            endcase
            if (dfr)
                step(3'h0);
        end
        summarize();
    end
endmodule : test_nested_interrupt_acknowledge

bind nia_core nia_core_properties #(.NUM_SOURCES(NUM_SOURCES), .NMI_VECTOR(NMI_VECTOR),
    .MASK_VECTOR_BASE(MASK_VECTOR_BASE)) u_props (.hclk(hclk), .hresetn(hresetn),
    .instr_done(instr_done), .instr_op(instr_op), .ack_valid(ack_valid),
    .ack_kind(ack_kind), .ack_source(ack_source), .ack_vector(ack_vector),
    .status_word(status_word));
